/* File: core/sdm_top.sv */
// Sectored data memory with direct and indirect address resolution.
//
// What this block does
// [R1] Lower half 00H..7FH of each sector decodes as special registers.
// [R2] Upper half 80H..FFH of sectors 0 and 1 is 256 bytes RAM.
// [R3] Unused special locations read 00H and store nothing.
// [R4] Pairs 1 and 2 take sector from high byte, address from low.
// [R5] Extended accesses carry 9 bits: top bit sector, low byte location.
// [R6] Standard direct accesses reach sector 0 only.
// [R7] Port access acts on the location its pointer designates.
// [R8] Port 0 reaches sector 0 only; ports 1 and 2 any sector.
// [R9] Port resolved as target reads 00H and ignores writes.
// [R10] The five pointer bytes are real, readable, writable, bit-modifiable.
// [R11] General RAM supports single-bit set and clear.
// [R12] Read-only special registers ignore program writes.
// [R13] Extended address 1F0H resolves to location 0F0H of sector 1.
// [R14] Only bit 0 of a sector pointer byte selects the sector.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defs.svh"

module sdm_top
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst,
   input  wire logic                i_acc_valid,
   input  wire logic                i_acc_ext,
   input  wire sdm_pkg::sdm_op_t    i_acc_op,
   input  wire logic      [8:0]     i_acc_addr,
   input  wire logic      [7:0]     i_acc_wdata,
   input  wire logic      [2:0]     i_acc_bit,
   output logic                     o_rd_valid,
   output logic           [7:0]     o_rd_data,
   output logic           [8:0]     o_rd_addr,
   output logic           [8:0]     o_sfr_raddr,
   input  wire logic      [7:0]     i_sfr_rdata,
   input  wire logic                i_sfr_present,
   input  wire logic                i_sfr_readonly,
   output logic                     o_sfr_we,
   output logic           [8:0]     o_sfr_waddr,
   output logic           [7:0]     o_sfr_wdata
);

   //---------------------------------------------------------------
   // State
   //---------------------------------------------------------------

   sdm_pkg::sdm_state_t st_reg;
   sdm_pkg::sdm_state_t st_next;

   //---------------------------------------------------------------
   // First decode: the address the instruction names
   //---------------------------------------------------------------

   logic              [8:0] req_addr;
   sdm_pkg::sdm_tgt_t       req_tgt;
   logic              [1:0] req_port;
   logic              [2:0] req_pidx;

   // Standard instructions carry only a byte, so sector 0 is forced.
   always_comb
   begin
      if (i_acc_ext)
      begin
         req_addr = i_acc_addr;                                     // [R5]
      end
      else
      begin
         req_addr = {1'b0, i_acc_addr[7:0]};                        // [R6]
      end
   end

   sdm_decode u_req_decode
   (
      .i_addr (req_addr),
      .o_tgt  (req_tgt),
      .o_port (req_port),
      .o_pidx (req_pidx)
   );

   //---------------------------------------------------------------
   // Indirect resolution through the pointer file
   //---------------------------------------------------------------

   logic       via_port;
   logic [8:0] eff_addr;
   logic       sec_one;
   logic       sec_two;

   assign via_port = (req_tgt == sdm_pkg::SDM_TGT_PORT);
   assign sec_one  = st_reg.ptr[`SDM_PIDX_PTR1S][`SDM_SECTOR_LSB];  // [R14]
   assign sec_two  = st_reg.ptr[`SDM_PIDX_PTR2S][`SDM_SECTOR_LSB];  // [R14]

   always_comb
   begin
      eff_addr = req_addr;
      if (via_port)                                                 // [R7]
      begin
         unique case (req_port)
            `SDM_PORT_ONE:
            begin
               eff_addr = {sec_one, st_reg.ptr[`SDM_PIDX_PTR1L]};   // [R4]
            end
            `SDM_PORT_TWO:
            begin
               eff_addr = {sec_two, st_reg.ptr[`SDM_PIDX_PTR2L]};   // [R4]
            end
            default:
            begin
               eff_addr = {1'b0, st_reg.ptr[`SDM_PIDX_PTR0]};       // [R8]
            end
         endcase
      end
   end

   //---------------------------------------------------------------
   // Second decode: the location finally acted on
   //---------------------------------------------------------------

   sdm_pkg::sdm_tgt_t       eff_tgt;
   logic              [2:0] eff_pidx;

   // A port is never a second-level indirection; as a target it is null.
   sdm_decode u_eff_decode
   (
      .i_addr (eff_addr),
      .o_tgt  (eff_tgt),
      .o_port (),
      .o_pidx (eff_pidx)
   );

   //---------------------------------------------------------------
   // General-purpose RAM
   //---------------------------------------------------------------

   logic [7:0] ram_idx;
   logic [7:0] ram_rdata;
   logic       ram_we;
   logic [7:0] new_byte;

   // Sector bit and the low seven bits of the upper half form the index.
   assign ram_idx = {eff_addr[`SDM_SECTOR_BIT], eff_addr[6:0]};     // [R2] [R13]

   sdm_ram u_ram
   (
      .i_ref_clk (i_ref_clk),
      .i_idx     (ram_idx),
      .i_we      (ram_we),
      .i_wdata   (new_byte),
      .o_rdata   (ram_rdata)
   );

   //---------------------------------------------------------------
   // Read value of the resolved location
   //---------------------------------------------------------------

   logic [7:0] old_byte;
   logic [7:0] bit_mask;
   logic       is_write;

   assign o_sfr_raddr = eff_addr;
   assign bit_mask    = 8'h01 << i_acc_bit;
   assign is_write    = i_acc_valid && (i_acc_op != sdm_pkg::SDM_OP_READ);

   always_comb
   begin
      unique case (eff_tgt)
         sdm_pkg::SDM_TGT_PORT:
         begin
            old_byte = `SDM_READ_ZERO;                              // [R9]
         end
         sdm_pkg::SDM_TGT_PTR:
         begin
            old_byte = st_reg.ptr[eff_pidx];                        // [R10]
         end
         sdm_pkg::SDM_TGT_GPR:
         begin
            old_byte = ram_rdata;                                   // [R2]
         end
         default:
         begin
            // Special area outside this block, or an unused location.
            if (i_sfr_present)                                      // [R1]
            begin
               old_byte = i_sfr_rdata;
            end
            else
            begin
               old_byte = `SDM_READ_ZERO;                           // [R3]
            end
         end
      endcase
   end

   //---------------------------------------------------------------
   // Byte write and single-bit modify
   //---------------------------------------------------------------

   // Bit operations are read-modify-write within the one access cycle.
   always_comb
   begin
      unique case (i_acc_op)
         sdm_pkg::SDM_OP_BSET:
         begin
            new_byte = old_byte | bit_mask;                         // [R11]
         end
         sdm_pkg::SDM_OP_BCLR:
         begin
            new_byte = old_byte & ~bit_mask;                        // [R11]
         end
         sdm_pkg::SDM_OP_WRITE:
         begin
            new_byte = i_acc_wdata;
         end
         default:
         begin
            new_byte = old_byte;
         end
      endcase
   end

   assign ram_we = is_write && (eff_tgt == sdm_pkg::SDM_TGT_GPR);   // [R2]

   //---------------------------------------------------------------
   // Next state
   //---------------------------------------------------------------

   logic sfr_take;

   // Writes to absent or protected special registers are dropped.
   assign sfr_take = is_write && (eff_tgt == sdm_pkg::SDM_TGT_SFR)
                     && i_sfr_present && !i_sfr_readonly;           // [R12] [R3]

   always_comb
   begin
      st_next          = st_reg;
      st_next.rd_valid = 1'b0;
      st_next.sfr_we   = 1'b0;
      if (i_acc_valid)
      begin
         st_next.rd_addr = eff_addr;
         if (i_acc_op == sdm_pkg::SDM_OP_READ)
         begin
            st_next.rd_valid = 1'b1;
            st_next.rd_data  = old_byte;
         end
      end
      if (is_write && (eff_tgt == sdm_pkg::SDM_TGT_PTR))
      begin
         st_next.ptr[eff_pidx] = new_byte;                          // [R10]
      end
      if (sfr_take)
      begin
         st_next.sfr_we    = 1'b1;
         st_next.sfr_waddr = eff_addr;
         st_next.sfr_wdata = new_byte;
      end
   end

   //---------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         st_reg.ptr       <= {5{`SDM_PTR_RST}};
         st_reg.rd_valid  <= 1'b0;
         st_reg.rd_data   <= `SDM_READ_ZERO;
         st_reg.rd_addr   <= 9'h000;
         st_reg.sfr_we    <= 1'b0;
         st_reg.sfr_waddr <= 9'h000;
         st_reg.sfr_wdata <= `SDM_READ_ZERO;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   //---------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------

   assign o_rd_valid  = st_reg.rd_valid;
   assign o_rd_data   = st_reg.rd_data;
   assign o_rd_addr   = st_reg.rd_addr;
   assign o_sfr_we    = st_reg.sfr_we;
   assign o_sfr_waddr = st_reg.sfr_waddr;
   assign o_sfr_wdata = st_reg.sfr_wdata;

endmodule
`default_nettype wire

/* File: core/sdm_defs.svh */
// Address offsets, field positions, reset values and fixed figures.
`ifndef SDM_DEFS_SVH
`define SDM_DEFS_SVH

// Sector 0 offsets of the indirect ports and the pointer bytes.
`define SDM_OFS_PORT0    7'h00
`define SDM_OFS_PTR0     7'h01
`define SDM_OFS_PORT1    7'h02
`define SDM_OFS_PTR1L    7'h03
`define SDM_OFS_PTR1S    7'h04
`define SDM_OFS_PORT2    7'h0C
`define SDM_OFS_PTR2L    7'h0D
`define SDM_OFS_PTR2S    7'h0E

// Bit 7 of the in-sector address marks the general-purpose half.
`define SDM_GP_BIT       7
// Bit 8 of a 9-bit address selects the sector.
`define SDM_SECTOR_BIT   8
// Bit of a sector pointer byte that takes part in decoding.
`define SDM_SECTOR_LSB   0

// Pointer byte indices inside the pointer file.
`define SDM_PIDX_PTR0    3'h0
`define SDM_PIDX_PTR1L   3'h1
`define SDM_PIDX_PTR1S   3'h2
`define SDM_PIDX_PTR2L   3'h3
`define SDM_PIDX_PTR2S   3'h4

// Port indices.
`define SDM_PORT_ZERO    2'h0
`define SDM_PORT_ONE     2'h1
`define SDM_PORT_TWO     2'h2

// Reset and null values.
`define SDM_PTR_RST      8'h00
`define SDM_READ_ZERO    8'h00

`endif

/* File: core/sdm_pkg.sv */
// Types shared by the sectored data memory files.
package sdm_pkg;

   typedef enum logic [1:0]
   {
      SDM_OP_READ  = 2'h0,
      SDM_OP_WRITE = 2'h1,
      SDM_OP_BSET  = 2'h2,
      SDM_OP_BCLR  = 2'h3
   } sdm_op_t;

   typedef enum logic [1:0]
   {
      SDM_TGT_PORT = 2'h0,
      SDM_TGT_PTR  = 2'h1,
      SDM_TGT_GPR  = 2'h2,
      SDM_TGT_SFR  = 2'h3
   } sdm_tgt_t;

   typedef struct packed
   {
      logic [255:0][7:0] mem;
   } sdm_ram_t;

   typedef struct packed
   {
      logic [4:0][7:0] ptr;
      logic            rd_valid;
      logic [7:0]      rd_data;
      logic [8:0]      rd_addr;
      logic            sfr_we;
      logic [8:0]      sfr_waddr;
      logic [7:0]      sfr_wdata;
   } sdm_state_t;

endpackage

/* File: core/sdm_decode.sv */
// Classifies one 9-bit data memory address.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defs.svh"

module sdm_decode
(
   input  wire logic [8:0]       i_addr,
   output var sdm_pkg::sdm_tgt_t o_tgt,
   output logic      [1:0]       o_port,
   output logic      [2:0]       o_pidx
);

   logic       sector0;
   logic [6:0] low;

   assign sector0 = ~i_addr[`SDM_SECTOR_BIT];
   assign low     = i_addr[6:0];

   always_comb
   begin
      o_port = `SDM_PORT_ZERO;
      o_pidx = `SDM_PIDX_PTR0;
      o_tgt  = sdm_pkg::SDM_TGT_SFR;
      if (i_addr[`SDM_GP_BIT])
      begin
         o_tgt = sdm_pkg::SDM_TGT_GPR;
      end
      else if (sector0)
      begin
         unique case (low)
            `SDM_OFS_PORT0:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PORT;
               o_port = `SDM_PORT_ZERO;
            end
            `SDM_OFS_PORT1:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PORT;
               o_port = `SDM_PORT_ONE;
            end
            `SDM_OFS_PORT2:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PORT;
               o_port = `SDM_PORT_TWO;
            end
            `SDM_OFS_PTR0:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PTR;
               o_pidx = `SDM_PIDX_PTR0;
            end
            `SDM_OFS_PTR1L:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PTR;
               o_pidx = `SDM_PIDX_PTR1L;
            end
            `SDM_OFS_PTR1S:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PTR;
               o_pidx = `SDM_PIDX_PTR1S;
            end
            `SDM_OFS_PTR2L:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PTR;
               o_pidx = `SDM_PIDX_PTR2L;
            end
            `SDM_OFS_PTR2S:
            begin
               o_tgt  = sdm_pkg::SDM_TGT_PTR;
               o_pidx = `SDM_PIDX_PTR2S;
            end
            default:
            begin
               o_tgt = sdm_pkg::SDM_TGT_SFR;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: core/sdm_ram.sv */
// General-purpose RAM of two sectors, 256 bytes in flip-flops.
`timescale 1ns/1ps
`default_nettype none

module sdm_ram
(
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_idx,
   input  wire logic       i_we,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata
);

   sdm_pkg::sdm_ram_t ram_reg;
   sdm_pkg::sdm_ram_t ram_next;

   assign o_rdata = ram_reg.mem[i_idx];

   always_comb
   begin
      ram_next = ram_reg;
      if (i_we)
      begin
         ram_next.mem[i_idx] = i_wdata;
      end
   end

   // Contents are data, not control, and so carry no reset.
   always_ff @(posedge i_ref_clk)
   begin
      ram_reg <= ram_next;
   end

endmodule
`default_nettype wire

/* File: bench/sdm_chk.sv */
// Concurrent checks on the ports of the sectored data memory.
`timescale 1ns/1ps
`default_nettype none
module sdm_chk
(
   input wire logic             i_ref_clk,
   input wire logic             i_rst,
   input wire logic             i_acc_valid,
   input wire logic             i_acc_ext,
   input wire sdm_pkg::sdm_op_t i_acc_op,
   input wire logic [8:0]       i_acc_addr,
   input wire logic [7:0]       i_acc_wdata,
   input wire logic [2:0]       i_acc_bit,
   input wire logic             o_rd_valid,
   input wire logic [7:0]       o_rd_data,
   input wire logic [8:0]       o_rd_addr,
   input wire logic [8:0]       o_sfr_raddr,
   input wire logic [7:0]       i_sfr_rdata,
   input wire logic             i_sfr_present,
   input wire logic             i_sfr_readonly,
   input wire logic             o_sfr_we,
   input wire logic [8:0]       o_sfr_waddr,
   input wire logic [7:0]       o_sfr_wdata
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   // True for an address served by the external special registers.
   function automatic logic is_sfr(input logic [8:0] a);
      return !a[7] && (a[8] || !(a[7:0] inside
         {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h0D, 8'h0E}));
   endfunction

   sequence s_read_req;
      i_acc_valid && i_acc_op == sdm_pkg::SDM_OP_READ;
   endsequence
   sequence s_sfr_ok;
      i_acc_valid && is_sfr(o_sfr_raddr) && i_sfr_present && !i_sfr_readonly;
   endsequence

   a_read_pulse: assert property (s_read_req |=> o_rd_valid)
      else $error("read without a data pulse");
   a_no_extra: assert property (
      !(i_acc_valid && i_acc_op == sdm_pkg::SDM_OP_READ) |=> !o_rd_valid)
      else $error("data pulse without a read");
   a_std_sector: assert property (
      i_acc_valid && !i_acc_ext && i_acc_addr[7]
      |=> o_rd_addr == ($past(i_acc_addr) & 9'h0FF))
      else $error("standard access left sector 0");
   a_ext_addr: assert property (
      i_acc_valid && i_acc_ext && i_acc_addr[7]
      |=> o_rd_addr == $past(i_acc_addr))
      else $error("extended address resolved wrongly");
   a_port0_sector: assert property (
      i_acc_valid && i_acc_addr[7:0] == 8'h00 && !(i_acc_ext && i_acc_addr[8])
      |=> !o_rd_addr[8])
      else $error("port zero reached sector 1");
   a_port_zero: assert property (
      o_rd_valid && !o_rd_addr[8] && o_rd_addr[7:0] inside {8'h00, 8'h02, 8'h0C}
      |-> o_rd_data == 8'h00)
      else $error("port as target read nonzero");
   a_sfr_write: assert property (
      i_acc_op == sdm_pkg::SDM_OP_WRITE ##0 s_sfr_ok
      |=> o_sfr_we && o_sfr_waddr == $past(o_sfr_raddr)
      && o_sfr_wdata == $past(i_acc_wdata))
      else $error("special register write lost");
   a_guard_write: assert property (
      !i_acc_valid || i_sfr_readonly || !i_sfr_present |=> !o_sfr_we)
      else $error("write to protected or absent register");
   a_bit_clear: assert property (
      i_acc_op == sdm_pkg::SDM_OP_BCLR ##0 s_sfr_ok
      |=> o_sfr_we
      && o_sfr_wdata == ($past(i_sfr_rdata) & ~(8'h01 << $past(i_acc_bit))))
      else $error("bit clear merged wrongly");
   a_hold_result: assert property (
      !i_acc_valid |=> $stable(o_rd_data) && $stable(o_rd_addr))
      else $error("result changed without access");
endmodule
`default_nettype wire

/* File: bench/sdm_sfr_model.sv */
// Model of the special registers that sit beside the data memory.
`timescale 1ns/1ps
`default_nettype none
module sdm_sfr_model
(
   input  wire logic       i_ref_clk,
   input  wire logic [8:0] i_raddr,
   input  wire logic       i_we,
   input  wire logic [8:0] i_waddr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output logic            o_present,
   output logic            o_readonly
);
   logic [7:0] regs [0:511];
   logic [7:0] noise;

   initial
   begin
      for (int i = 0; i < 512; i++)
         regs[i] = i[7:0] ^ 8'h3C;
      noise = 8'hA5;
   end

   // Absent places drive a changing pattern so a leak is never hidden.
   always @(posedge i_ref_clk)
   begin
      noise <= {noise[6:0], ~noise[7]};
      // Stores whatever it is sent, so a leaked protected write shows up.
      if (i_we)
         regs[i_waddr] <= i_wdata;
   end

   assign o_present = (i_raddr >= 9'h005 && i_raddr <= 9'h00B)
                      || i_raddr == 9'h140;
   assign o_readonly = i_raddr == 9'h00A;
   assign o_rdata = o_present ? regs[i_raddr] : noise;
endmodule
`default_nettype wire

/* File: bench/tb_sdm_top.sv */
// Self-checking testbench of the sectored data memory.
`timescale 1ns/1ps
`default_nettype none
module tb_sdm_top;
   logic             clk;
   logic             rst;
   logic             valid;
   logic             ext;
   sdm_pkg::sdm_op_t op;
   logic [8:0]       addr;
   logic [7:0]       wdata;
   logic [2:0]       bitn;
   logic             rd_valid;
   logic [7:0]       rd_data;
   logic [8:0]       rd_addr;
   logic [8:0]       sfr_raddr;
   logic [7:0]       sfr_rdata;
   logic             sfr_present;
   logic             sfr_ro;
   logic             sfr_we;
   logic [8:0]       sfr_waddr;
   logic [7:0]       sfr_wdata;
   int               n_mismatch;
   int               compares;
   int               cycles;

   sdm_top i_dut
   (
      .i_ref_clk(clk), .i_rst(rst), .i_acc_valid(valid), .i_acc_ext(ext),
      .i_acc_op(op), .i_acc_addr(addr), .i_acc_wdata(wdata),
      .i_acc_bit(bitn), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .o_rd_addr(rd_addr), .o_sfr_raddr(sfr_raddr), .i_sfr_rdata(sfr_rdata),
      .i_sfr_present(sfr_present), .i_sfr_readonly(sfr_ro),
      .o_sfr_we(sfr_we), .o_sfr_waddr(sfr_waddr), .o_sfr_wdata(sfr_wdata)
   );

   sdm_sfr_model i_sfr
   (
      .i_ref_clk(clk), .i_raddr(sfr_raddr), .i_we(sfr_we),
      .i_waddr(sfr_waddr), .i_wdata(sfr_wdata), .o_rdata(sfr_rdata),
      .o_present(sfr_present), .o_readonly(sfr_ro)
   );

   initial
      clk = 1'b0;
   always #5 clk = ~clk;

   task automatic conclude;
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One access held for exactly one taking edge.
   task automatic acc(input logic e, input sdm_pkg::sdm_op_t o,
                      input logic [8:0] a, input logic [7:0] d,
                      input logic [2:0] b);
      @(posedge clk);
      #1;
      valid = 1'b1;
      ext = e;
      op = o;
      addr = a;
      wdata = d;
      bitn = b;
      @(posedge clk);
      #1;
      valid = 1'b0;
   endtask

   task automatic wr(input logic e, input logic [8:0] a, input logic [7:0] d);
      acc(e, sdm_pkg::SDM_OP_WRITE, a, d, 3'h0);
   endtask

   task automatic rd(input logic e, input logic [8:0] a, input logic [7:0] x);
      acc(e, sdm_pkg::SDM_OP_READ, a, 8'h00, 3'h0);
      chk("rd_valid", 8'h01, {7'h00, rd_valid});
      chk("rd_data", x, rd_data);
   endtask

   task automatic t_reset;
      chk("rd_valid", 8'h00, {7'h00, rd_valid});
      chk("rd_data", 8'h00, rd_data);
      rd(1'b0, 9'h001, 8'h00);
   endtask

   task automatic t_ram;
      wr(1'b0, 9'h085, 8'h3C);
      wr(1'b1, 9'h185, 8'hC3);
      wr(1'b0, 9'h0F0, 8'h11);
      wr(1'b1, 9'h1F0, 8'h77);
      rd(1'b0, 9'h085, 8'h3C);
      rd(1'b1, 9'h185, 8'hC3);
      rd(1'b1, 9'h1F0, 8'h77);
      rd(1'b0, 9'h1F0, 8'h11);
   endtask

   task automatic t_bits;
      wr(1'b1, 9'h1A0, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         acc(1'b1, sdm_pkg::SDM_OP_BSET, 9'h1A0, 8'h00, i[2:0]);
         rd(1'b1, 9'h1A0, 8'((16'h0002 << i) - 1));
      end
      acc(1'b1, sdm_pkg::SDM_OP_BCLR, 9'h1A0, 8'h00, 3'h3);
      rd(1'b1, 9'h1A0, 8'hF7);
   endtask

   task automatic t_ptr;
      logic [8:0] ofs [5] = '{9'h001, 9'h003, 9'h004, 9'h00D, 9'h00E};
      for (int i = 0; i < 5; i++)
      begin
         wr(1'b0, ofs[i], 8'hC0 | i[7:0]);
         rd(1'b0, ofs[i], 8'hC0 | i[7:0]);
      end
      wr(1'b0, 9'h004, 8'hFE);
      acc(1'b0, sdm_pkg::SDM_OP_BSET, 9'h004, 8'h00, 3'h0);
      rd(1'b0, 9'h004, 8'hFF);
   endtask

   task automatic t_ind;
      wr(1'b0, 9'h001, 8'h85);
      rd(1'b0, 9'h000, 8'h3C);
      wr(1'b0, 9'h003, 8'h85);
      rd(1'b0, 9'h002, 8'hC3);
      wr(1'b0, 9'h00E, 8'h00);
      wr(1'b0, 9'h00D, 8'hA0);
      wr(1'b0, 9'h00C, 8'h5D);
      rd(1'b0, 9'h0A0, 8'h5D);
      wr(1'b0, 9'h00E, 8'h01);
      rd(1'b1, 9'h00C, 8'hF7);
      wr(1'b0, 9'h001, 8'hA0);
      rd(1'b0, 9'h000, 8'h5D);
      wr(1'b0, 9'h001, 8'h02);
      rd(1'b0, 9'h000, 8'h00);
      wr(1'b0, 9'h000, 8'h99);
      rd(1'b0, 9'h001, 8'h02);
      rd(1'b0, 9'h003, 8'h85);
   endtask

   task automatic t_sfr;
      wr(1'b0, 9'h007, 8'h5A);
      rd(1'b0, 9'h007, 8'h5A);
      acc(1'b0, sdm_pkg::SDM_OP_BCLR, 9'h007, 8'h00, 3'h1);
      rd(1'b0, 9'h007, 8'h58);
      wr(1'b0, 9'h00A, 8'hFF);
      rd(1'b0, 9'h00A, 8'h36);
      rd(1'b0, 9'h013, 8'h00);
      rd(1'b1, 9'h100, 8'h00);
      wr(1'b1, 9'h140, 8'h6B);
      rd(1'b1, 9'h140, 8'h6B);
      rd(1'b0, 9'h140, 8'h00);
      wr(1'b0, 9'h004, 8'h01);
      wr(1'b0, 9'h003, 8'h40);
      rd(1'b0, 9'h002, 8'h6B);
   endtask

   // Reset in mid-run: sector pointers at 004 and 00E return to 00, RAM contents survive.
   task automatic t_rst;
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("rd_valid", 8'h00, {7'h00, rd_valid});
      chk("sfr_we", 8'h00, {7'h00, sfr_we});
      rd(1'b0, 9'h004, 8'h00);
      rd(1'b0, 9'h00E, 8'h00);
      rd(1'b0, 9'h085, 8'h3C);
   endtask

   initial
   begin
      n_mismatch = 0;
      compares = 0;
      cycles = 0;
      rst = 1'b1;
      valid = 1'b0;
      ext = 1'b0;
      op = sdm_pkg::SDM_OP_READ;
      addr = 9'h000;
      wdata = 8'h00;
      bitn = 3'h0;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_ram();
      t_bits();
      t_ptr();
      t_ind();
      t_sfr();
      t_rst();
      conclude();
   end
endmodule

bind sdm_top sdm_chk i_chk
(
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_acc_valid(i_acc_valid),
   .i_acc_ext(i_acc_ext), .i_acc_op(i_acc_op), .i_acc_addr(i_acc_addr),
   .i_acc_wdata(i_acc_wdata), .i_acc_bit(i_acc_bit),
   .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_addr(o_rd_addr),
   .o_sfr_raddr(o_sfr_raddr), .i_sfr_rdata(i_sfr_rdata),
   .i_sfr_present(i_sfr_present), .i_sfr_readonly(i_sfr_readonly),
   .o_sfr_we(o_sfr_we), .o_sfr_waddr(o_sfr_waddr), .o_sfr_wdata(o_sfr_wdata)
);
`default_nettype wire
